// >>> hw/cbrd_regs.svh
// Offsets, field positions, reset values and masks of the relocation decode.
`ifndef CBRD_REGS_SVH
`define CBRD_REGS_SVH
// ==========================================================================
// Register offsets within the 256-byte peripheral register block.
`define CBRD_OFS_RELOC      8'hFE
`define CBRD_OFS_RESCFG     8'hF6
// ==========================================================================
// Relocation register fields and reset value.
`define CBRD_RELOC_RESET    16'h20FF
`define CBRD_RELOC_WMASK    16'h5FFF
`define CBRD_BIT_SLAVE      14
`define CBRD_BIT_MEM        12
`define CBRD_BASE_HI        11
`define CBRD_BASE_LO        0
`define CBRD_IO_CMP_HI      7
`define CBRD_BASE_LOW_BITS  8'h00
`define CBRD_ZERO16         16'h0000
`define CBRD_PULL_LEVEL     16'hFFFF
// ==========================================================================
// Host command port offsets.
`define CBRD_H_ADDR         8'h00
`define CBRD_H_CTRL         8'h04
`define CBRD_H_WDATA        8'h08
`define CBRD_H_STATUS       8'h0C
`define CBRD_H_RDATA        8'h10
`define CBRD_H_RESET        8'h14
`define CBRD_H_STRAP        8'h18
`define CBRD_H_CTRL_WRITE   0
`define CBRD_H_CTRL_MEM     1
`define CBRD_H_RST_HOLD     0
`define CBRD_H_RST_STRAP    1
`endif

// >>> hw/cbrd_pkg.sv
// Types shared by both ends of the relocation decode link.
package cbrd_pkg;
   // =======================================================================
   // Host bus-cycle sequencer states, one-hot.
   typedef enum logic [2:0] {
      CBRD_S_IDLE  = 3'b001,
      CBRD_S_ISSUE = 3'b010,
      CBRD_S_RESP  = 3'b100
   } cbrd_host_st_t;

   // =======================================================================
   // Whole state of the decode end.
   typedef struct packed {
      logic [15:0] reloc;
      logic [15:0] rescfg;
      logic        hit;
      logic [15:0] rdata;
   } cbrd_dev_state_t;

   // =======================================================================
   // Whole state of the bus-unit end.
   typedef struct packed {
      cbrd_host_st_t st;
      logic          strobe;
      logic          mem;
      logic          write;
      logic [19:0]   addr;
      logic [15:0]   wdata;
      logic [15:0]   ad_out;
      logic          ad_oe;
      logic [7:0]    ao_hi;
      logic [15:0]   rdata;
      logic          hit_seen;
      logic          done;
      logic          rst_hold;
      logic          strap_en;
      logic [15:0]   strap;
      logic [31:0]   sw_rdata;
   } cbrd_host_state_t;
endpackage

// >>> hw/cbrd_if.sv
// Link between the processor bus unit and the register block decode.
`timescale 1ns/100ps
`default_nettype none
`include "cbrd_regs.svh"
interface cbrd_if;
   logic        cyc_strobe;       // One-cycle bus cycle request.
   logic        cyc_mem;          // 1 memory space, 0 I/O space.
   logic        cyc_write;
   logic [19:0] cyc_addr;
   logic [15:0] cyc_wdata;        // Internal write data path.
   logic [15:0] biu_ad_out;
   logic        biu_ad_oe;
   logic [7:0]  upper_address_only_lines;
   logic        reset_input_low;
   logic        dev_hit;
   logic [15:0] dev_rdata;
   logic [15:0] muxed_addr_data_bus;

   // Undriven lines float high through weak pull-ups.
   assign muxed_addr_data_bus = biu_ad_oe ? biu_ad_out : `CBRD_PULL_LEVEL;

   modport dev (
      input  cyc_strobe, cyc_mem, cyc_write, cyc_addr, cyc_wdata,
      input  upper_address_only_lines, reset_input_low, muxed_addr_data_bus,
      output dev_hit, dev_rdata
   );
   modport host (
      output cyc_strobe, cyc_mem, cyc_write, cyc_addr, cyc_wdata,
      output biu_ad_out, biu_ad_oe, upper_address_only_lines,
      output reset_input_low,
      input  dev_hit, dev_rdata, muxed_addr_data_bus
   );
endinterface
`default_nettype wire

// >>> hw/cbrd_addr_match.sv
// Base-address comparator for the 256-byte register block.
`timescale 1ns/100ps
`default_nettype none
`include "cbrd_regs.svh"
module cbrd_addr_match (
   input  wire logic [15:0] reloc_in,
   input  wire logic [19:0] addr_in,
   input  wire logic        mem_in,
   output logic             hit_out
);
   // =======================================================================
   // Space and window compare.
   always_comb begin
      if (reloc_in[`CBRD_BIT_MEM] != mem_in) begin
         hit_out = 1'b0;
      end else if (mem_in) begin
         hit_out = (addr_in[19:8] ==
                    reloc_in[`CBRD_BASE_HI:`CBRD_BASE_LO]);
      end else begin
         hit_out = (addr_in[15:8] ==
                    reloc_in[`CBRD_IO_CMP_HI:`CBRD_BASE_LO]);
      end
   end
endmodule
`default_nettype wire

// >>> hw/cbrd_device.sv
// Register block decode end: relocation register and reset configuration latch.
`timescale 1ns/100ps
`default_nettype none
`include "cbrd_regs.svh"
// ==========================================================================
// Overview.
// A bus cycle hits when its address falls in the
// 256-byte window set by the relocation register.
// Only the relocation register and the reset
// configuration latch live here; other offsets
// read zero and drop writes.
// Internal answers never use the external data
// bus or the ready inputs.
// While the link reset is low the relocation
// register reloads and the latch follows the pins
// on every enabled edge, so it keeps the value of
// the last edge before the reset rises.
// Limitation: a link reset that spans no enabled
// edge is not seen at all.
// ==========================================================================
module cbrd_device (
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   input  wire logic        ce_in,
   input  wire logic        narrow_bus_in,
   cbrd_if.dev              link,
   output logic             slave_mode_out,
   output logic             mem_space_out,
   output logic [19:0]      base_addr_out
);
   // =======================================================================
   // State. One packed record, so the clock enable
   // and both resets act on every field alike and no
   // field can slip out of the freeze.
   cbrd_pkg::cbrd_dev_state_t st_r;
   cbrd_pkg::cbrd_dev_state_t st_nxt;
   logic                      match;
   logic [7:0]                offset;
   logic                      in_link_reset;
   logic [15:0]               captured;

   // =======================================================================
   // Offset decode, shared by the write and read
   // paths so that they never disagree on which
   // register an offset selects.
   function automatic logic is_reloc_ofs(input logic [7:0] ofs);
      return (ofs == `CBRD_OFS_RELOC);
   endfunction

   function automatic logic is_rescfg_ofs(input logic [7:0] ofs);
      return (ofs == `CBRD_OFS_RESCFG);
   endfunction

   // Relocation write. Reserved bits keep what
   // reset loaded, so a read always shows the
   // reset pattern there; the others take the data.
   function automatic logic [15:0] reloc_merge(
      input logic [15:0] old_val,
      input logic [15:0] wr_val
   );
      return (wr_val & `CBRD_RELOC_WMASK) |
             (old_val & ~`CBRD_RELOC_WMASK);
   endfunction

   // =======================================================================
   // Window compare against the stored relocation value. The comparator
   // sees the registered value only, so a new base applies from the next
   // cycle on and a cycle in flight is never split between two bases.
   // The cost is one cycle of answer latency,
   // which the bus unit's response state absorbs.
   // In I/O space only address bits 15-8 are
   // compared, so the top base bits do not matter.
   // upper base bits
   cbrd_addr_match u_match (
      .reloc_in (st_r.reloc),
      .addr_in  (link.cyc_addr),
      .mem_in   (link.cyc_mem),
      .hit_out  (match)
   );

   // The offset is the low byte of the address; the base itself always has
   // zeros there, so the window is 256 bytes and aligned.
   // The link reset is active low; the inverted copy
   // keeps the next-state logic in the positive sense.
   // window offset
   assign offset        = link.cyc_addr[7:0];
   assign in_link_reset = ~link.reset_input_low;

   // =======================================================================
   // Strap value as it stands on the pins. On the narrow bus the upper byte
   // comes from the address-only lines and bit 0 is not a strap.
   // Bit 0 reads zero on the narrow bus so it is
   // defined on both widths. The width select is a
   // level and must not move while a capture runs.
   always_comb begin
      if (narrow_bus_in) begin
         captured = {link.upper_address_only_lines,
                     link.muxed_addr_data_bus[7:1], 1'b0};
      end else begin
         captured = link.muxed_addr_data_bus;
      end
   end

   // =======================================================================
   // Next-state logic: reset capture, register writes and read answers.
   // Each field starts from its present value and
   // holds unless a branch changes it; only the hit
   // pulse is cleared every cycle.
   always_comb begin
      st_nxt     = st_r;
      st_nxt.hit = 1'b0;
      // A link reset wins over a request in the same
      // cycle: the strobe is dropped, not answered
      // against a base that is being reloaded.
      if (in_link_reset) begin
         st_nxt.reloc  = `CBRD_RELOC_RESET;
         st_nxt.rescfg = captured;
         st_nxt.rdata  = `CBRD_ZERO16;
      end else if (link.cyc_strobe) begin
         st_nxt.hit = match;
         if (match && link.cyc_write) begin
            if (is_reloc_ofs(offset)) begin
               st_nxt.reloc = reloc_merge(st_r.reloc, link.cyc_wdata);
            end
            // configuration is read-only
            // A write to the latch offset is dropped on
            // purpose: only a link reset or the asynchronous reset changes it.
         end else if (match) begin
            // configuration readback
            // The answer is registered: it stands beside
            // the hit pulse and holds until the next read or link reset.
            if (is_rescfg_ofs(offset)) begin
               st_nxt.rdata = st_r.rescfg;
            end else if (is_reloc_ofs(offset)) begin
               st_nxt.rdata = st_r.reloc;
            // Other peripherals answer their own offsets; here they read 0.
            end else begin
               st_nxt.rdata = `CBRD_ZERO16;
            end
         end
      end
   end

   // =======================================================================
   // State register. The clock enable freezes every field; the link reset is
   // handled synchronously above so that the strap pins can be sampled.
   // The asynchronous reset clears the latch: no
   // strap value exists before the first link reset.
   // A low enable also freezes the capture, so a
   // link reset ending then keeps the last value.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r.reloc  <= `CBRD_RELOC_RESET;
         st_r.rescfg <= `CBRD_ZERO16;
         st_r.hit    <= 1'b0;
         st_r.rdata  <= `CBRD_ZERO16;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   // =======================================================================
   // Outputs, all taken from the registered state.
   // Mode and base change in the cycle after a
   // relocation write, together with the decode, so
   // no watcher sees a base the decode is not using.
   assign link.dev_hit   = st_r.hit;
   assign link.dev_rdata = st_r.rdata;
   assign slave_mode_out = st_r.reloc[`CBRD_BIT_SLAVE];
   assign mem_space_out  = st_r.reloc[`CBRD_BIT_MEM];
   assign base_addr_out  = {st_r.reloc[`CBRD_BASE_HI:`CBRD_BASE_LO],
                            `CBRD_BASE_LOW_BITS};
endmodule
`default_nettype wire

// >>> hw/cbrd_host.sv
// Processor bus unit end: issues memory and I/O cycles and drives reset.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "cbrd_regs.svh"
module cbrd_host (
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   input  wire logic        ce_in,
   input  wire logic [7:0]  sw_addr_in,
   input  wire logic [31:0] sw_wdata_in,
   input  wire logic        sw_wr_in,
   input  wire logic        sw_rd_in,
   output logic [31:0]      sw_rdata_out,
   input  wire logic        sync_ready_in,
   input  wire logic        async_ready_in,
   output logic             busy_out,
   cbrd_if.host             link
);
   // =======================================================================
   // State.
   cbrd_pkg::cbrd_host_state_t st_r;
   cbrd_pkg::cbrd_host_state_t st_nxt;
   logic                       idle;

   assign idle = (st_r.st == cbrd_pkg::CBRD_S_IDLE);

   // =======================================================================
   // Command registers, bus sequencer and read port.
   always_comb begin
      st_nxt        = st_r;
      st_nxt.strobe = 1'b0;
      if (sw_wr_in) begin
         unique case (sw_addr_in)
            `CBRD_H_ADDR:  st_nxt.addr = sw_wdata_in[19:0];
            `CBRD_H_WDATA: st_nxt.wdata = sw_wdata_in[15:0];
            `CBRD_H_STRAP: st_nxt.strap = sw_wdata_in[15:0];
            `CBRD_H_RESET: begin
               st_nxt.rst_hold = sw_wdata_in[`CBRD_H_RST_HOLD];
               st_nxt.strap_en = sw_wdata_in[`CBRD_H_RST_STRAP];
            end
            // I/O top address bits go out as software wrote them
            // A launch while busy or in reset is ignored.
            `CBRD_H_CTRL: begin
               if (idle && !st_r.rst_hold) begin
                  st_nxt.write    = sw_wdata_in[`CBRD_H_CTRL_WRITE];
                  st_nxt.mem      = sw_wdata_in[`CBRD_H_CTRL_MEM];
                  st_nxt.strobe   = 1'b1;
                  st_nxt.done     = 1'b0;
                  st_nxt.st       = cbrd_pkg::CBRD_S_ISSUE;
               end
            end
            default: ;
         endcase
      end
      unique case (st_r.st)
         cbrd_pkg::CBRD_S_IDLE: ;
         cbrd_pkg::CBRD_S_ISSUE: st_nxt.st = cbrd_pkg::CBRD_S_RESP;
         cbrd_pkg::CBRD_S_RESP: begin
            if (link.dev_hit) begin
               st_nxt.rdata    = link.dev_rdata;
               st_nxt.hit_seen = 1'b1;
               st_nxt.done     = 1'b1;
               st_nxt.st       = cbrd_pkg::CBRD_S_IDLE;
            end else if (sync_ready_in || async_ready_in) begin
               st_nxt.rdata    = link.muxed_addr_data_bus;
               st_nxt.hit_seen = 1'b0;
               st_nxt.done     = 1'b1;
               st_nxt.st       = cbrd_pkg::CBRD_S_IDLE;
            end
         end
      endcase
      // Pins: strap drive only in reset, otherwise a normal external cycle.
      if (st_nxt.rst_hold) begin
         st_nxt.ad_oe  = st_nxt.strap_en;
         st_nxt.ad_out = st_nxt.strap;
         st_nxt.ao_hi  = st_nxt.strap[15:8];
      end else begin
         st_nxt.ad_oe  = st_nxt.write &&
                         (st_nxt.st != cbrd_pkg::CBRD_S_IDLE);
         st_nxt.ad_out = st_nxt.wdata;
         st_nxt.ao_hi  = st_nxt.addr[15:8];
      end
      st_nxt.sw_rdata = 32'h0000_0000;
      if (sw_rd_in) begin
         unique case (sw_addr_in)
            `CBRD_H_ADDR:   st_nxt.sw_rdata = {12'h000, st_r.addr};
            `CBRD_H_CTRL:   st_nxt.sw_rdata = {30'h0000_0000, st_r.mem,
                                               st_r.write};
            `CBRD_H_WDATA:  st_nxt.sw_rdata = {16'h0000, st_r.wdata};
            `CBRD_H_STATUS: st_nxt.sw_rdata = {29'h0000_0000, st_r.hit_seen,
                                               st_r.done, ~idle};
            `CBRD_H_RDATA:  st_nxt.sw_rdata = {16'h0000, st_r.rdata};
            `CBRD_H_RESET:  st_nxt.sw_rdata = {30'h0000_0000, st_r.strap_en,
                                               st_r.rst_hold};
            `CBRD_H_STRAP:  st_nxt.sw_rdata = {16'h0000, st_r.strap};
            default:        st_nxt.sw_rdata = 32'h0000_0000;
         endcase
      end
   end

   // =======================================================================
   // State register.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r    <= '0;
         st_r.st <= cbrd_pkg::CBRD_S_IDLE;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   // =======================================================================
   // Outputs straight from the state register.
   assign link.cyc_strobe               = st_r.strobe;
   assign link.cyc_mem                  = st_r.mem;
   assign link.cyc_write                = st_r.write;
   assign link.cyc_addr                 = st_r.addr;
   assign link.cyc_wdata                = st_r.wdata;
   assign link.biu_ad_out               = st_r.ad_out;
   assign link.biu_ad_oe                = st_r.ad_oe;
   assign link.upper_address_only_lines = st_r.ao_hi;
   assign link.reset_input_low          = ~st_r.rst_hold;
   assign sw_rdata_out                  = st_r.sw_rdata;
   assign busy_out                      = ~idle;
endmodule
`default_nettype wire

// >>> tb/cbrd_link_props.sv
// Concurrent checks on the link between the bus unit and the block decode.
`timescale 1ns/100ps
`default_nettype none
module cbrd_link_props (
   input wire logic        clock_in,
   input wire logic        rst_b_in,
   input wire logic        cyc_strobe,
   input wire logic        cyc_mem,
   input wire logic        cyc_write,
   input wire logic [19:0] cyc_addr,
   input wire logic [15:0] cyc_wdata,
   input wire logic        reset_input_low,
   input wire logic        dev_hit,
   input wire logic [15:0] dev_rdata
);
   logic [15:0] shd_r;  // Relocation value the decode must be using.
   logic        win;
   logic        req;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // =====
   // Shadow relocation register
   // A link reset reloads the default, so the shadow must follow it too.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shd_r <= 16'h20FF;
      end else if (!reset_input_low) begin
         shd_r <= 16'h20FF;
      end else if (req && win && cyc_write && cyc_addr[7:0] == 8'hFE) begin
         shd_r <= (cyc_wdata & 16'h5FFF) | 16'h2000;
      end
   end
   // I/O space compares address bits 15-8 only, memory space 19-8.
   assign req = cyc_strobe && reset_input_low;
   assign win = (cyc_mem == shd_r[12]) && (shd_r[12] ?
                cyc_addr[19:8] == shd_r[11:0] : cyc_addr[15:8] == shd_r[7:0]);
   // =====
   // Decode answers
   a_hit_in_window: assert property (req && win |=> dev_hit)
      else $error("no answer inside the window");
   a_miss_no_answer: assert property (req && !win |=> !dev_hit)
      else $error("answer outside the window");
   a_io_top_ignored: assert property (req && !cyc_mem && !shd_r[12] &&
      cyc_addr[15:8] == shd_r[7:0] |=> dev_hit)
      else $error("I/O hit lost on top address bits");
   a_reloc_read_back: assert property (req && win && !cyc_write &&
      cyc_addr[7:0] == 8'hFE |=> dev_rdata == shd_r)
      else $error("relocation read back wrong");
   a_unused_reads_zero: assert property (req && win && !cyc_write &&
      cyc_addr[7:0] != 8'hFE && cyc_addr[7:0] != 8'hF6 |=> dev_rdata == 16'h0)
      else $error("unassigned offset not zero");
   a_hit_has_cause: assert property (dev_hit |-> $past(req))
      else $error("answer without a request");
   a_link_reset_mute: assert property (!reset_input_low |=> !dev_hit)
      else $error("answer during link reset");
   a_hit_one_cycle: assert property (dev_hit |=> !dev_hit)
      else $error("answer longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/control_block_relocation_decode_tb.sv
// Self-checking bench joining the bus unit end to the block decode end.
`timescale 1ns/100ps
`default_nettype none
`include "cbrd_regs.svh"
module control_block_relocation_decode_tb;
   logic        clock_in;
   logic        rst_b_in;
   logic        narrow_bus_in;
   logic [7:0]  sw_addr_in;
   logic [31:0] sw_wdata_in;
   logic        sw_wr_in;
   logic        sw_rd_in;
   logic [31:0] sw_rdata_out;
   logic        sync_ready_in;
   logic        async_ready_in;
   logic        busy_out;
   logic        slave_mode_out;
   logic        mem_space_out;
   logic [19:0] base_addr_out;
   logic [15:0] cur;  // Relocation value software last set.
   integer      fail_count;
   integer      total_checks;
   integer      seed;
   integer      cycles = 0;
   cbrd_if link ();
   cbrd_host cbrd_host_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .ce_in(1'b1), .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
      .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
      .sync_ready_in(sync_ready_in), .async_ready_in(async_ready_in),
      .busy_out(busy_out), .link(link));
   cbrd_device cbrd_device_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .ce_in(1'b1), .narrow_bus_in(narrow_bus_in), .link(link),
      .slave_mode_out(slave_mode_out), .mem_space_out(mem_space_out),
      .base_addr_out(base_addr_out));
   cbrd_link_props cbrd_link_props_inst (.clock_in(clock_in),
      .rst_b_in(rst_b_in), .cyc_strobe(link.cyc_strobe),
      .cyc_mem(link.cyc_mem), .cyc_write(link.cyc_write),
      .cyc_addr(link.cyc_addr), .cyc_wdata(link.cyc_wdata),
      .reset_input_low(link.reset_input_low), .dev_hit(link.dev_hit),
      .dev_rdata(link.dev_rdata));
   // =====
   // Clock and watchdog
   // The ceiling is far above the fewer than 1000 cycles the tests need.
   initial clock_in = 1'b0;
   always #12.5 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         stop_test();
      end
   end
   // =====
   // Compare and report tasks
   task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_val({19'h0, got}, {19'h0, exp});
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // =====
   // Expectations
   // I/O decode ignores address bits 19-16, so they are drawn at random.
   function automatic logic in_win(input logic [15:0] r, input logic m,
                                   input logic [19:0] a);
      return (m == r[12]) && (r[12] ? a[19:8] == r[11:0] : a[15:8] == r[7:0]);
   endfunction
   function automatic logic [19:0] at(input logic [15:0] r, input logic [7:0] o);
      logic [31:0] n;
      n = $random(seed);
      return r[12] ? {r[11:0], o} : {n[3:0], r[7:0], o};
   endfunction
   // =====
   // Software port and bus cycle tasks
   task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      sw_addr_in  <= a;
      sw_wdata_in <= d;
      sw_wr_in    <= 1'b1;
      @(posedge clock_in);
      sw_wr_in <= 1'b0;
   endtask
   task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_in);
      sw_addr_in <= a;
      sw_rd_in   <= 1'b1;
      @(posedge clock_in);
      sw_rd_in <= 1'b0;
      #1;
      d = sw_rdata_out;
   endtask
   // Ready is random on hits, which must ignore it; misses need it high.
   task automatic bus_cyc(input logic w, input logic m, input logic [19:0] a,
      input logic [15:0] wd, output logic hit, output logic [15:0] rd);
      logic [31:0] st;
      logic [31:0] n;
      integer      k;
      sw_wr(`CBRD_H_ADDR, {12'h000, a});
      n = $random(seed);
      sync_ready_in  <= in_win(cur, m, a) ? n[0] : 1'b1;
      async_ready_in <= n[1];
      sw_wr(`CBRD_H_WDATA, {16'h0000, wd});
      sw_wr(`CBRD_H_CTRL, {30'h0, m, w});
      k = 0;
      do begin
         sw_rd(`CBRD_H_STATUS, st);
         k = k + 1;
      end while (st[0] && k < 20);
      chk_flag(st[0], 1'b0);
      chk_flag(busy_out, 1'b0);
      hit = st[2];
      sw_rd(`CBRD_H_RDATA, n);
      rd = n[15:0];
   endtask
   task automatic rd_reg(input logic [7:0] o, input logic [15:0] exp);
      logic        hit;
      logic [15:0] d;
      bus_cyc(1'b0, cur[12], at(cur, o), 16'h0000, hit, d);
      chk_flag(hit, 1'b1);
      chk_val({4'h0, d}, {4'h0, exp});
   endtask
   task automatic chk_outs(input logic [15:0] r);
      chk_flag(slave_mode_out, r[14]);
      chk_flag(mem_space_out, r[12]);
      chk_val(base_addr_out, {r[11:0], 8'h00});
   endtask
   // Strap value held on the bus through the whole link reset.
   task automatic strap_cap(input logic [15:0] s, input logic nb,
                            input logic en);
      logic [15:0] e;
      // undriven data lines read as pull-ups
      e = nb ? {s[15:8], (en ? s[7:1] : 7'h7F), 1'b0} : (en ? s : 16'hFFFF);
      sw_wr(`CBRD_H_STRAP, {16'h0000, s});
      narrow_bus_in <= nb;
      sw_wr(`CBRD_H_RESET, {30'h0, en, 1'b1});
      repeat (4) @(posedge clock_in);
      sw_wr(`CBRD_H_RESET, {30'h0, en, 1'b0});
      sw_wr(`CBRD_H_RESET, 32'h0);
      cur = 16'h20FF;
      rd_reg(`CBRD_OFS_RESCFG, e);
   endtask
   // =====
   // Main sequence
   initial begin
      logic        hit;
      logic [15:0] d;
      logic [15:0] r;
      logic [15:0] old;
      logic [19:0] a;
      logic [31:0] n;
      integer      i;
      seed = 59746;
      fail_count = 0;
      total_checks = 0;
      cur = 16'h20FF;
      rst_b_in = 1'b0;
      {narrow_bus_in, sw_wr_in, sw_rd_in, sync_ready_in, async_ready_in} = 5'h0;
      sw_addr_in = 8'h00;
      sw_wdata_in = 32'h0;
      repeat (20) @(posedge clock_in);
      rst_b_in <= 1'b1;
      @(posedge clock_in);
      chk_outs(16'h20FF);
      rd_reg(`CBRD_OFS_RELOC, 16'h20FF);
      $display("test reset defaults done");
      for (i = 0; i < 12; i++) begin
         n = $random(seed);
         r = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h4000 : n[15:0];
         if (!r[12]) r[11:8] = 4'h0;
         old = cur;
         bus_cyc(1'b1, cur[12], at(cur, `CBRD_OFS_RELOC), r, hit, d);
         cur = (r & 16'h5FFF) | 16'h2000; // Reserved bits keep reset.
         chk_flag(hit, 1'b1);
         chk_outs(cur);
         rd_reg(`CBRD_OFS_RELOC, cur);
         // unassigned offset 10 still hits and reads zero; peripherals live elsewhere.
         rd_reg(8'h10, 16'h0000);
         a = at(old, `CBRD_OFS_RELOC);
         bus_cyc(1'b0, old[12], a, 16'h0000, hit, d);
         chk_flag(hit, in_win(cur, old[12], a));
      end
      $display("test relocation done");
      for (i = 0; i < 4; i++) begin
         n = $random(seed);
         strap_cap(n[15:0], i[0], 1'b1);
         rd_reg(`CBRD_OFS_RELOC, 16'h20FF);
         bus_cyc(1'b1, 1'b0, at(cur, `CBRD_OFS_RESCFG), ~n[15:0], hit, d);
         rd_reg(`CBRD_OFS_RESCFG, i[0] ? {n[15:1], 1'b0} : n[15:0]);
      end
      strap_cap(16'h1234, 1'b0, 1'b0);
      $display("test reset capture done");
      stop_test();
   end
endmodule
`default_nettype wire
